// ---- smbus_engine_defs.vh ----
// Purpose: Shared constants of the two-wire master engine
// Assumes: 10 MHz core clock
// Notes:   Included by bare name; definitions only
`ifndef SMBUS_ENGINE_DEFS_VH
`define SMBUS_ENGINE_DEFS_VH

// Clock and time base
`define CLK_FREQ_HZ        10000000
`define MS_PER_S           1000

// Configuration reset values and auto-send on code
`define SCL_HALF_RESET     16'h0032
`define OWN_ADDR_RESET     8'h02
`define AUTO_SEND_ON       8'h01
`define AUTO_SEND_RESET    8'h00

// Limits, in ms or counts
`define SCL_LOW_TIMEOUT_MS 6'h19
`define TIMEOUT_MAX_MS     10'h3E8
`define RETRY_MAX          10'h3E8
`define LOG_ADDR_MAX       5'h10

// Request kinds
`define KIND_WRITE         2'h0
`define KIND_READ          2'h1
`define KIND_ADDR_READ     2'h2

// Completion status codes
`define ST_OK              3'h0
`define ST_NACK            3'h1
`define ST_ARB_LOST        3'h2
`define ST_TIMEOUT         3'h3
`define ST_SCL_LOW         3'h4
`define ST_RETRY_LIMIT     3'h5

// Byte segments of a transaction
`define SEG_ADDR           3'h0
`define SEG_LOG            3'h1
`define SEG_WDATA          3'h2
`define SEG_RADDR          3'h3
`define SEG_RDATA          3'h4

// Read data buffer
`define DATA_W             8
`define FIFO_DEPTH         4

`endif

// ---- smbus_tick_gen.v ----
// Purpose: One-cycle enable pulse every 'period' clocks
// Assumes: period of 0 or 1 ticks every cycle
// Notes:   clear restarts the count and masks the tick
`timescale 1ns/100ps
module smbus_tick_gen #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         clear,
  input  wire [W-1:0] period,
  output wire         tick
);
  reg  [W-1:0] cnt_q;
  wire [W:0]   cntNext = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};

  assign tick = ~clear & (cntNext >= {1'b0, period});

  always @(posedge clk) begin
    if (rst || clear || tick)
      cnt_q <= {W{1'b0}};
    else
      cnt_q <= cntNext[W-1:0];
  end
endmodule // smbus_tick_gen

// ---- smbus_fifo.v ----
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, AW = log2(DEPTH)
// Notes:   Output data comes straight from the storage flops
`timescale 1ns/100ps
module smbus_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            push = inValid & inReady;
  wire            pop  = outValid & outReady;
  localparam [AW:0] FULL = DEPTH;

  assign inReady  = (count_q != FULL);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData  = mem_q[rdPtr_q];

  always @(posedge clk) begin
    if (push)
      mem_q[wrPtr_q] <= inData;
  end

  always @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // smbus_fifo

// ---- smbus_master_bridge_engine.v ----
// Purpose: Byte-level two-wire master engine with own-address acknowledge
// Assumes: 10 MHz clk; SCL/SDA are open-drain pins with external pull-ups
// Notes:   Read bytes pass a small FIFO; a full FIFO stretches SCL low
//
// How it works
// - START, address byte (addr in 7..1, direction in 0), data, STOP.
// - Direction bit is 1 for read, 0 for write.
// - Receiver pulls SDA low on ninth clock; high means not-acknowledge.
// - Write: one byte at a time, slave acknowledge sampled after each.
// - Read: slave drives bytes, master returns acknowledge bit after each.
// - STOP after the final byte ends the transaction and frees the bus.
// - Addressed read: write address, logical bytes, repeated START, read.
// - Logical address length is one to sixteen bytes.
// - Arbitration: a master seeing SDA low while sending one withdraws.
// - Own address acknowledged, LSB ignored, requests to it never serviced.
// - SCL rate configurable; 10 kHz to 400 kHz recommended.
// - Auto-send 0x01 forwards reads; 0x00 holds them until host request.
// - Read and write timeouts 0 to 1000 ms cancel transfer; 0 disables.
// - SCL low over 25 ms is a timeout; reset communication within 10 ms.
// - Retry limit 0 to 1000 caps attempts; 0 means unlimited.
// - Configuration changes never take effect during a transfer.
// - SCL and SDA are only pulled low or released.
// - Engine makes SCL, syncs with stretching, makes START/STOP, arbitrates.
// - Host works in whole bytes; engine handles every bit itself.
`timescale 1ns/100ps
`include "smbus_engine_defs.vh"
module smbus_master_bridge_engine #(
  parameter [23:0] MS_CYCLES  = `CLK_FREQ_HZ / `MS_PER_S,
  parameter        FIFO_DEPTH = `FIFO_DEPTH,
  parameter        FIFO_AW    = 2
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        sclIn,
  output wire        sclOut,
  output wire        sclOeN,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOeN,
  input  wire        cmdValid,
  output wire        cmdReady,
  input  wire [1:0]  cmdKind,
  input  wire [6:0]  cmdAddr,
  input  wire [9:0]  cmdLen,
  input  wire [4:0]  cmdLogLen,
  input  wire        wrValid,
  output wire        wrReady,
  input  wire [7:0]  wrData,
  output wire        rdValid,
  input  wire        rdReady,
  output wire [7:0]  rdData,
  input  wire        rdRespReq,
  input  wire [15:0] cfgSclHalf,
  input  wire [7:0]  cfgOwnAddr,
  input  wire [7:0]  cfgAutoSend,
  input  wire [9:0]  cfgRdTimeoutMs,
  input  wire [9:0]  cfgWrTimeoutMs,
  input  wire        cfgSclLowEn,
  input  wire [9:0]  cfgRetryLimit,
  output wire        busy,
  output wire        busBusy,
  output wire        doneValid,
  output wire [2:0]  doneStatus
);
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_ARM   = 4'h1;
  localparam [3:0] S_STA   = 4'h2;
  localparam [3:0] S_BLOW  = 4'h3;
  localparam [3:0] S_BHIGH = 4'h4;
  localparam [3:0] S_NEXT  = 4'h5;
  localparam [3:0] S_LOAD  = 4'h6;
  localparam [3:0] S_PUSH  = 4'h7;
  localparam [3:0] S_STOPA = 4'h8;
  localparam [3:0] S_STOPB = 4'h9;
  localparam [3:0] S_STOPC = 4'hA;
  localparam [3:0] S_RSA   = 4'hB;
  localparam [3:0] S_RSB   = 4'hC;

  reg        sclM_q, sclS_q, sclP_q;
  reg        sdaM_q, sdaS_q, sdaP_q;
  reg        busBusy_q;
  reg [5:0]  lowMs_q;
  reg [15:0] shHalf_q;
  reg [7:0]  shOwn_q;
  reg [7:0]  shAuto_q;
  reg [9:0]  shRdTo_q, shWrTo_q, shRetry_q;
  reg        shLowEn_q;
  reg        slvOn_q, slvAck_q;
  reg [3:0]  slvCnt_q;
  reg [7:0]  slvSh_q;
  reg        grant_q;
  reg [3:0]  state_q;
  reg [2:0]  seg_q;
  reg [1:0]  kind_q;
  reg [6:0]  addr_q;
  reg [9:0]  lenA_q, lenB_q, remaining_q;
  reg [7:0]  txSh_q, rxSh_q;
  reg [3:0]  bitCnt_q;
  reg        highSeen_q, ackOk_q, retryAfter_q;
  reg [9:0]  retries_q, elapsed_q;
  reg [2:0]  stCode_q;
  reg        sclRel_q, sdaRel_q, phClr_q;
  reg        doneValid_q;
  reg [2:0]  doneStatus_q;

  wire       sclTick, msTick;
  wire       fifoInReady, fifoOutValid;
  wire       startSeen = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
  wire       stopSeen  = sclS_q & sclP_q & ~sdaP_q & sdaS_q;
  wire       sclRise   = sclS_q & ~sclP_q;
  wire       sclFall   = ~sclS_q & sclP_q;
  wire       lowTo     = shLowEn_q & (lowMs_q > `SCL_LOW_TIMEOUT_MS);
  wire       rxMode    = (seg_q == `SEG_RDATA);
  wire [9:0] toLimit   = (kind_q == `KIND_WRITE) ? shWrTo_q : shRdTo_q;
  wire       toHit     = (toLimit != 10'h000) & (elapsed_q >= toLimit);
  wire       autoOn    = (shAuto_q == `AUTO_SEND_ON);
  wire       rdOpen    = autoOn | grant_q;
  wire [4:0] logClamp  = (cmdLogLen == 5'h00) ? 5'h01 :
                         (cmdLogLen > `LOG_ADDR_MAX) ? `LOG_ADDR_MAX : cmdLogLen;
  wire       bitVal    = (bitCnt_q == 4'h8) ? (rxMode ? (remaining_q == 10'h001) : 1'b1)
                                            : (rxMode ? 1'b1 : txSh_q[7]);

  // Open-drain pins: only ever pull low or release
  assign sclOut     = 1'b0;
  assign sdaOut     = 1'b0;
  assign sclOeN     = sclRel_q;
  assign sdaOeN     = sdaRel_q & ~slvAck_q;
  assign cmdReady   = (state_q == S_IDLE);
  assign wrReady    = (state_q == S_LOAD);
  assign busy       = (state_q != S_IDLE);
  assign busBusy    = busBusy_q;
  assign doneValid  = doneValid_q;
  assign doneStatus = doneStatus_q;
  assign rdValid    = fifoOutValid & rdOpen;

  smbus_tick_gen #(.W(16)) u_sclTick (
    .clk    (clk),
    .rst    (rst),
    .clear  (phClr_q),
    .period (shHalf_q),
    .tick   (sclTick)
  );

  smbus_tick_gen #(.W(24)) u_msTick (
    .clk    (clk),
    .rst    (rst),
    .clear  (1'b0),
    .period (MS_CYCLES),
    .tick   (msTick)
  );

  smbus_fifo #(.WIDTH(`DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rdFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (state_q == S_PUSH),
    .inReady  (fifoInReady),
    .inData   (rxSh_q),
    .outValid (fifoOutValid),
    .outReady (rdReady & rdOpen),
    .outData  (rdData)
  );

  // Pin synchronisers and edge history
  always @(posedge clk) begin
    if (rst) begin
      sclM_q <= 1'b1;
      sclS_q <= 1'b1;
      sclP_q <= 1'b1;
      sdaM_q <= 1'b1;
      sdaS_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclM_q <= sclIn;
      sclS_q <= sclM_q;
      sclP_q <= sclS_q;
      sdaM_q <= sdaIn;
      sdaS_q <= sdaM_q;
      sdaP_q <= sdaS_q;
    end
  end

  // Bus free/busy and SCL-low watchdog
  always @(posedge clk) begin
    if (rst) begin
      busBusy_q <= 1'b0;
      lowMs_q   <= 6'h00;
    end else begin
      if (sclS_q)
        lowMs_q <= 6'h00;
      else if (msTick && lowMs_q != 6'h3F)
        lowMs_q <= lowMs_q + 6'h01;
      if (startSeen)
        busBusy_q <= 1'b1;
      else if (stopSeen || lowTo)
        busBusy_q <= 1'b0;
    end
  end

  // Settings copied only while no transfer runs
  always @(posedge clk) begin
    if (rst) begin
      shHalf_q  <= `SCL_HALF_RESET;
      shOwn_q   <= `OWN_ADDR_RESET;
      shAuto_q  <= `AUTO_SEND_RESET;
      shRdTo_q  <= 10'h000;
      shWrTo_q  <= 10'h000;
      shRetry_q <= 10'h000;
      shLowEn_q <= 1'b0;
    end else if (state_q == S_IDLE && !cmdValid) begin
      shHalf_q  <= cfgSclHalf;
      shOwn_q   <= cfgOwnAddr;
      shAuto_q  <= cfgAutoSend;
      shRdTo_q  <= (cfgRdTimeoutMs > `TIMEOUT_MAX_MS) ? `TIMEOUT_MAX_MS : cfgRdTimeoutMs;
      shWrTo_q  <= (cfgWrTimeoutMs > `TIMEOUT_MAX_MS) ? `TIMEOUT_MAX_MS : cfgWrTimeoutMs;
      shRetry_q <= (cfgRetryLimit > `RETRY_MAX) ? `RETRY_MAX : cfgRetryLimit;
      shLowEn_q <= cfgSclLowEn;
    end
  end

  // Own-address listener; acknowledges only, never serves data
  always @(posedge clk) begin
    if (rst || state_q != S_IDLE) begin
      slvOn_q  <= 1'b0;
      slvAck_q <= 1'b0;
      slvCnt_q <= 4'h0;
      slvSh_q  <= 8'h00;
    end else if (startSeen) begin
      slvOn_q  <= 1'b1;
      slvAck_q <= 1'b0;
      slvCnt_q <= 4'h0;
    end else if (stopSeen) begin
      slvOn_q  <= 1'b0;
      slvAck_q <= 1'b0;
    end else if (slvOn_q) begin
      if (sclRise && slvCnt_q < 4'h8) begin
        slvSh_q  <= {slvSh_q[6:0], sdaS_q};
        slvCnt_q <= slvCnt_q + 4'h1;
      end else if (sclFall && slvCnt_q == 4'h8) begin
        slvAck_q <= (slvSh_q[7:1] == shOwn_q[7:1]);
        slvCnt_q <= 4'h9;
      end else if (sclFall && slvCnt_q == 4'h9) begin
        slvAck_q <= 1'b0;
        slvCnt_q <= 4'hA;
      end
    end
  end

  // Held read data released by an explicit host request
  always @(posedge clk) begin
    if (rst)
      grant_q <= 1'b0;
    else if (rdRespReq)
      grant_q <= 1'b1;
    else if (!fifoOutValid && state_q == S_IDLE)
      grant_q <= 1'b0;
  end

  task go;
    input [3:0] s;
    begin
      state_q <= s;
      phClr_q <= 1'b1;
    end
  endtask

  task finish;
    input [2:0] code;
    begin
      sclRel_q     <= 1'b1;
      sdaRel_q     <= 1'b1;
      doneValid_q  <= 1'b1;
      doneStatus_q <= code;
      retryAfter_q <= 1'b0;
      go(S_IDLE);
    end
  endtask

  // Transaction and bit sequencer
  always @(posedge clk) begin
    if (rst) begin
      state_q      <= S_IDLE;
      seg_q        <= `SEG_ADDR;
      kind_q       <= `KIND_WRITE;
      addr_q       <= 7'h00;
      lenA_q       <= 10'h000;
      lenB_q       <= 10'h000;
      remaining_q  <= 10'h000;
      txSh_q       <= 8'h00;
      rxSh_q       <= 8'h00;
      bitCnt_q     <= 4'h0;
      highSeen_q   <= 1'b0;
      ackOk_q      <= 1'b0;
      retryAfter_q <= 1'b0;
      retries_q    <= 10'h000;
      elapsed_q    <= 10'h000;
      stCode_q     <= `ST_OK;
      sclRel_q     <= 1'b1;
      sdaRel_q     <= 1'b1;
      phClr_q      <= 1'b0;
      doneValid_q  <= 1'b0;
      doneStatus_q <= `ST_OK;
    end else begin
      phClr_q     <= 1'b0;
      doneValid_q <= 1'b0;
      if (msTick && state_q != S_IDLE && elapsed_q != 10'h3FF)
        elapsed_q <= elapsed_q + 10'h001;
      case (state_q)
        S_IDLE: begin
          if (cmdValid) begin
            kind_q    <= cmdKind;
            addr_q    <= cmdAddr;
            txSh_q    <= {cmdAddr, cmdKind == `KIND_READ};
            bitCnt_q  <= 4'h0;
            seg_q     <= `SEG_ADDR;
            retries_q <= 10'h000;
            elapsed_q <= 10'h000;
            lenA_q    <= (cmdKind == `KIND_ADDR_READ) ? {5'h00, logClamp} :
                         (cmdKind == `KIND_WRITE) ? cmdLen : 10'h000;
            lenB_q    <= (cmdLen == 10'h000) ? 10'h001 : cmdLen;
            go(S_ARM);
          end
        end
        S_ARM: begin
          if (!busBusy_q && sclS_q && sdaS_q) begin
            sdaRel_q <= 1'b0;
            go(S_STA);
          end
        end
        S_STA: begin
          if (sclTick) begin
            sclRel_q <= 1'b0;
            go(S_BLOW);
          end
        end
        S_BLOW: begin
          if (phClr_q)
            sdaRel_q <= bitVal;
          else if (sclTick) begin
            sclRel_q   <= 1'b1;
            highSeen_q <= 1'b0;
            go(S_BHIGH);
          end
        end
        S_BHIGH: begin
          if (!highSeen_q) begin
            if (sclS_q) begin
              highSeen_q <= 1'b1;
              phClr_q    <= 1'b1;
            end
          end else if (sclTick || !sclS_q) begin
            sclRel_q <= 1'b0;
            if (bitCnt_q < 4'h8 && !rxMode && txSh_q[7] && !sdaS_q)
              finish(`ST_ARB_LOST);
            else if (bitCnt_q == 4'h8) begin
              ackOk_q  <= ~sdaS_q;
              bitCnt_q <= 4'h0;
              go(S_NEXT);
            end else begin
              rxSh_q   <= {rxSh_q[6:0], sdaS_q};
              txSh_q   <= {txSh_q[6:0], 1'b1};
              bitCnt_q <= bitCnt_q + 4'h1;
              go(S_BLOW);
            end
          end
        end
        S_NEXT: begin
          case (seg_q)
            `SEG_ADDR: begin
              if (!ackOk_q) begin
                if (shRetry_q != 10'h000 && retries_q + 10'h001 >= shRetry_q)
                  stCode_q <= `ST_RETRY_LIMIT;
                else
                  retryAfter_q <= 1'b1;
                retries_q <= retries_q + 10'h001;
                go(S_STOPA);
              end else if (kind_q == `KIND_READ) begin
                seg_q       <= `SEG_RDATA;
                remaining_q <= lenB_q;
                go(S_BLOW);
              end else if (lenA_q == 10'h000) begin
                stCode_q <= `ST_OK;
                go(S_STOPA);
              end else begin
                seg_q       <= (kind_q == `KIND_ADDR_READ) ? `SEG_LOG : `SEG_WDATA;
                remaining_q <= lenA_q;
                go(S_LOAD);
              end
            end
            `SEG_LOG, `SEG_WDATA: begin
              if (!ackOk_q) begin
                stCode_q <= `ST_NACK;
                go(S_STOPA);
              end else if (remaining_q == 10'h001) begin
                stCode_q <= `ST_OK;
                go((seg_q == `SEG_LOG) ? S_RSA : S_STOPA);
              end else begin
                remaining_q <= remaining_q - 10'h001;
                go(S_LOAD);
              end
            end
            `SEG_RADDR: begin
              if (!ackOk_q) begin
                stCode_q <= `ST_NACK;
                go(S_STOPA);
              end else begin
                seg_q       <= `SEG_RDATA;
                remaining_q <= lenB_q;
                go(S_BLOW);
              end
            end
            default: go(S_PUSH);
          endcase
        end
        S_LOAD: begin
          if (wrValid) begin
            txSh_q <= wrData;
            go(S_BLOW);
          end
        end
        S_PUSH: begin
          if (fifoInReady) begin
            if (remaining_q == 10'h001) begin
              stCode_q <= `ST_OK;
              go(S_STOPA);
            end else begin
              remaining_q <= remaining_q - 10'h001;
              go(S_BLOW);
            end
          end
        end
        S_STOPA: begin
          if (phClr_q)
            sdaRel_q <= 1'b0;
          else if (sclTick) begin
            sclRel_q   <= 1'b1;
            highSeen_q <= 1'b0;
            go(S_STOPB);
          end
        end
        S_STOPB: begin
          if (!highSeen_q) begin
            if (sclS_q) begin
              highSeen_q <= 1'b1;
              phClr_q    <= 1'b1;
            end
          end else if (sclTick) begin
            sdaRel_q <= 1'b1;
            go(S_STOPC);
          end
        end
        S_STOPC: begin
          if (sclTick) begin
            if (retryAfter_q) begin
              retryAfter_q <= 1'b0;
              seg_q        <= `SEG_ADDR;
              txSh_q       <= {addr_q, kind_q == `KIND_READ};
              go(S_ARM);
            end else
              finish(stCode_q);
          end
        end
        S_RSA: begin
          if (phClr_q)
            sdaRel_q <= 1'b1;
          else if (sclTick) begin
            sclRel_q   <= 1'b1;
            highSeen_q <= 1'b0;
            go(S_RSB);
          end
        end
        S_RSB: begin
          if (!highSeen_q) begin
            if (sclS_q) begin
              highSeen_q <= 1'b1;
              phClr_q    <= 1'b1;
            end
          end else if (sclTick) begin
            sdaRel_q <= 1'b0;
            seg_q    <= `SEG_RADDR;
            txSh_q   <= {addr_q, 1'b1};
            go(S_STA);
          end
        end
        default: finish(`ST_OK);
      endcase
      if (state_q != S_IDLE && lowTo)
        finish(`ST_SCL_LOW);
      else if (state_q != S_IDLE && toHit)
        finish(`ST_TIMEOUT);
    end
  end
endmodule // smbus_master_bridge_engine

// ---- smbus_slave_model.sv ----
// Purpose: Behavioural two-wire slave at address ADDR
// Assumes: Lines are the wired levels with pull-ups
// Notes:   Read data counts up from 8'hA5 after each START
`timescale 1ns/100ps
module smbus_slave_model #(
  parameter [6:0] ADDR = 7'h50
) (
  input  wire scl,
  input  wire sda,
  input  wire slow,
  output reg  sclOeN = 1'b1,
  output reg  sdaOeN = 1'b1
);
  reg [7:0] shift, txByte;
  reg [3:0] bitCnt;
  reg       active = 1'b0, isAddr, reading;
  reg [7:0] got[$];
  always @(negedge sda) begin
    if (scl) begin
      active = 1'b1;
      isAddr = 1'b1;
      reading = 1'b0;
      bitCnt = 4'h0;
      txByte = 8'hA5;
    end
  end
  always @(posedge sda) begin
    if (scl)
      active = 1'b0;
  end
  always @(posedge scl) begin
    if (bitCnt < 4'h8)
      shift = {shift[6:0], sda};
    else if (reading && sda)
      active = 1'b0;
    bitCnt = bitCnt + 4'h1;
    if (active && !reading && bitCnt == 4'h8)
      got.push_back(shift);
  end
  always @(negedge scl) begin
    sdaOeN = 1'b1;
    if (bitCnt == 4'h9)
      bitCnt = 4'h0;
    if (active && bitCnt == 4'h8) begin
      if (isAddr) begin
        active = shift[7:1] == ADDR;
        sdaOeN = !active;
        reading = shift[0];
        isAddr = 1'b0;
      end else if (!reading)
        sdaOeN = 1'b0;
      else
        txByte = txByte + 8'h01;
    end else if (active && reading)
      sdaOeN = txByte[7 - bitCnt];
    if (slow && bitCnt == 4'h8) begin
      sclOeN = 1'b0;
      #3000 sclOeN = 1'b1;
    end
  end
endmodule // smbus_slave_model

// ---- smbus_master_bridge_engine_checker.sv ----
// Purpose: Port assertions for the two-wire master engine
// Assumes: MS_CYCLES matches the engine
// Notes:   Bound to every engine instance
`timescale 1ns/100ps
module smbus_master_bridge_engine_checker #(
  parameter [23:0] MS_CYCLES = 24'h002710
) (
  input wire       clk,
  input wire       rst,
  input wire       sclIn,
  input wire       sclOut,
  input wire       sclOeN,
  input wire       sdaOut,
  input wire       sdaOeN,
  input wire       cmdValid,
  input wire       cmdReady,
  input wire       cfgSclLowEn,
  input wire       busy,
  input wire       doneValid,
  input wire [2:0] doneStatus
);
  reg [23:0] lowCnt_q;
  always @(posedge clk) begin
    if (rst || sclIn || !busy || !cfgSclLowEn)
      lowCnt_q <= 24'h000000;
    else
      lowCnt_q <= lowCnt_q + 24'h000001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence take_s;
    cmdValid && cmdReady;
  endsequence
  sequence work_s;
    busy && !cmdReady;
  endsequence
  drive_zero_a: assert property (!sclOut && !sdaOut)
    else $error("pin data not zero");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> sclOeN && sdaOeN && !busy && !doneValid)
    else $error("not idle after reset");
  take_busy_a: assert property (take_s |=> work_s)
    else $error("request not started");
  rose_take_a: assert property ($rose(busy) |-> $past(cmdValid && cmdReady))
    else $error("busy without request");
  ready_idle_a: assert property (cmdReady == !busy)
    else $error("ready while busy");
  done_pulse_a: assert property (doneValid |=> !doneValid)
    else $error("done too long");
  done_code_a: assert property (doneValid |-> doneStatus <= 3'h5 && $past(busy))
    else $error("bad completion");
  cancel_free_a: assert property (doneValid && (doneStatus == 3'h2 || doneStatus == 3'h4) |-> ##[0:2] (sclOeN && sdaOeN))
    else $error("lines held after cancel");
  low_bound_a: assert property (lowCnt_q < 36 * MS_CYCLES)
    else $error("clock low too long");
endmodule // smbus_master_bridge_engine_checker
bind smbus_master_bridge_engine smbus_master_bridge_engine_checker #(.MS_CYCLES(MS_CYCLES)) chk (
  .clk, .rst, .sclIn, .sclOut, .sclOeN, .sdaOut, .sdaOeN, .cmdValid, .cmdReady,
  .cfgSclLowEn, .busy, .doneValid, .doneStatus
);

// ---- smbus_master_bridge_engine_bench.sv ----
// Purpose: Self-checking bench for the two-wire master engine
// Assumes: Slave model at 7'h50; SCL period 1300 ns
// Notes:   MS_CYCLES shortened to 20 so timeouts stay brief
`timescale 1ns/100ps
module smbus_master_bridge_engine_bench;
  reg         clk = 1'b0, rst = 1'b1, cmdValid = 1'b0, wrValid = 1'b1, rdReady = 1'b1;
  reg         rdRespReq = 1'b0, cfgSclLowEn = 1'b0, tbScl = 1'b1, tbSda = 1'b1, slow = 1'b0;
  reg  [1:0]  cmdKind = 2'h0;
  reg  [6:0]  cmdAddr = 7'h00;
  reg  [4:0]  cmdLogLen = 5'h02;
  reg  [9:0]  cmdLen = 10'h000, cfgRdTimeoutMs = 10'h000, cfgWrTimeoutMs = 10'h000, cfgRetryLimit = 10'h000;
  reg  [7:0]  wrData = 8'h3C, cfgOwnAddr = 8'h22, cfgAutoSend = 8'h01;
  reg  [15:0] cfgSclHalf = 16'h0004;
  wire        sclOut, sclOeN, sdaOut, sdaOeN, cmdReady, wrReady, rdValid, busy, busBusy, doneValid;
  wire        slvScl, slvSda;
  wire [7:0]  rdData;
  wire [2:0]  doneStatus;
  wire        sclIn = sclOeN & slvScl & tbScl;
  wire        sdaIn = sdaOeN & slvSda & tbSda;
  integer     fail_count = 0, num_checks = 0;
  reg  [7:0]  rxq[$];
  smbus_master_bridge_engine #(.MS_CYCLES(24'h000014)) dut (
    .clk, .rst, .sclIn, .sclOut, .sclOeN, .sdaIn, .sdaOut, .sdaOeN, .cmdValid, .cmdReady,
    .cmdKind, .cmdAddr, .cmdLen, .cmdLogLen, .wrValid, .wrReady, .wrData, .rdValid, .rdReady,
    .rdData, .rdRespReq, .cfgSclHalf, .cfgOwnAddr, .cfgAutoSend, .cfgRdTimeoutMs,
    .cfgWrTimeoutMs, .cfgSclLowEn, .cfgRetryLimit, .busy, .busBusy, .doneValid, .doneStatus
  );
  smbus_slave_model slv (.scl(sclIn), .sda(sdaIn), .slow, .sclOeN(slvScl), .sdaOeN(slvSda));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (wrValid && wrReady)
      wrData <= wrData + 8'h11;
    if (rdValid && rdReady)
      rxq.push_back(rdData);
  end
  task check(input [31:0] seen, input [31:0] expVal);
    begin
      num_checks = num_checks + 1;
      if (seen !== expVal) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen=%h exp=%h", $time, seen, expVal);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (fail_count == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task xfer(input [1:0] kind, input [6:0] addr, input [9:0] len, input [2:0] expSt);
    integer i;
    begin
      @(posedge clk);
      slv.got.delete();
      rxq.delete();
      cmdKind <= kind;
      cmdAddr <= addr;
      cmdLen <= len;
      cmdValid <= 1'b1;
      @(posedge clk);
      cmdValid <= 1'b0;
      i = 0;
      while (doneValid !== 1'b1 && i < 5000) begin
        @(posedge clk);
        i = i + 1;
      end
      check({doneValid, doneStatus}, {1'b1, expSt});
    end
  endtask
  task own_probe(input [7:0] b, input ack);
    integer k;
    reg [8:0] bits;
    begin
      bits = {b, 1'b1};
      tbSda <= 1'b0;
      repeat (4) @(posedge clk);
      for (k = 8; k >= 0; k = k - 1) begin
        tbScl <= 1'b0;
        repeat (2) @(posedge clk);
        tbSda <= bits[k];
        repeat (2) @(posedge clk);
        tbScl <= 1'b1;
        repeat (4) @(posedge clk);
      end
      check({sdaOeN, busBusy}, {!ack, 1'b1});
      tbScl <= 1'b0;
      repeat (4) @(posedge clk);
      check({sdaOeN, busy}, 32'h2);
      tbSda <= 1'b0;
      repeat (2) @(posedge clk);
      tbScl <= 1'b1;
      repeat (4) @(posedge clk);
      tbSda <= 1'b1;
      repeat (4) @(posedge clk);
      check(busBusy, 32'h0);
    end
  endtask
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({sclOeN, sdaOeN, cmdReady, busy, doneValid}, 32'h1C);
    own_probe(8'h23, 1'b1);
    own_probe(8'h44, 1'b0);
    xfer(2'h0, 7'h50, 10'h002, 3'h0);
    check({slv.got[0], slv.got[1], slv.got[2]}, 32'hA03C4D);
    check(slv.active, 32'h0);
    slow <= 1'b1;
    rdReady <= 1'b0;
    fork
      xfer(2'h1, 7'h50, 10'h006, 3'h0);
      begin
        repeat (1100) @(posedge clk);
        check({rdValid, busy, rxq.size() == 0, sclOeN}, 32'hE);
        rdReady <= 1'b1;
      end
    join
    check({rxq[0], rxq[5], slv.got[0]}, 32'hA5AAA1);
    cfgAutoSend <= 8'h00;
    xfer(2'h2, 7'h50, 10'h001, 3'h0);
    repeat (20) @(posedge clk);
    check(rxq.size(), 32'h0);
    rdRespReq <= 1'b1;
    @(posedge clk);
    rdRespReq <= 1'b0;
    repeat (5) @(posedge clk);
    check({rxq[0], slv.got[0], slv.got[3]}, 32'hA5A0A1);
    check(slv.got.size(), 32'h4);
    cfgRetryLimit <= 10'h002;
    xfer(2'h0, 7'h33, 10'h001, 3'h5);
    check(slv.got.size(), 32'h2);
    cfgRetryLimit <= 10'h000;
    fork
      xfer(2'h0, 7'h50, 10'h001, 3'h2);
      begin
        @(negedge sdaOeN);
        @(posedge clk);
        tbSda <= 1'b0;
      end
    join
    tbSda <= 1'b1;
    cfgSclLowEn <= 1'b1;
    fork
      xfer(2'h0, 7'h50, 10'h001, 3'h4);
      begin
        @(negedge sdaOeN);
        @(posedge clk);
        tbScl <= 1'b0;
      end
    join
    tbScl <= 1'b1;
    cfgSclLowEn <= 1'b0;
    wrValid <= 1'b0;
    cfgWrTimeoutMs <= 10'h008;
    xfer(2'h0, 7'h50, 10'h001, 3'h3);
    tally_and_finish;
  end
endmodule // smbus_master_bridge_engine_bench
